// ==== logic/adc_cfg_buf.sv ====
// Two-entry valid/ready buffer for committed settings
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_buf #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // Filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0] slot_r [2];
    logic         rd_ptr_r;
    logic         wr_ptr_r;
    logic [1:0]   count_r;
    logic         push;
    logic         pop;

    // Honest full and empty flags
    assign in_ready  = (count_r != 2'h2);
    assign out_valid = (count_r != 2'h0);
    assign out_data  = slot_r[rd_ptr_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage is written only on a push
    always_ff @(posedge clk_sys) begin
        if (push) begin
            slot_r[wr_ptr_r] <= in_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_ptr_r <= 1'b0;
            wr_ptr_r <= 1'b0;
            count_r  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            count_r <= count_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : adc_cfg_buf
`default_nettype wire

// ==== logic/adc_config.sv ====
// Audio delay configuration register bank with staged commit and mute hold
`timescale 1ns/1ps
`default_nettype none
module adc_config (
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    // Register byte port from the two-wire slave framing
    input  wire logic                   reg_start,
    input  wire logic [7:0]             reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_rd,
    output logic [7:0]                  reg_rdata,
    output logic                        reg_rvalid,
    // Committed settings toward the delay datapath
    output logic                        cfg_valid,
    input  wire logic                   cfg_ready,
    output adc_pkg::adc_cfg_t           cfg_data,
    // Sample progress from the datapath
    input  wire logic                   sample_tick,
    // Channel mutes
    output logic                        mute_left,
    output logic                        mute_right,
    // Status
    output logic                        commit_busy
);
    import adc_pkg::*;

    logic [7:0]  ptr_r;
    logic [7:0]  ctrl_r;
    logic [7:0]  right_up_r;
    logic [7:0]  right_lo_r;
    logic [7:0]  left_up_r;
    logic [7:0]  left_lo_r;
    logic [7:0]  frame_r;
    logic [7:0]  payload_r;
    logic [7:0]  commit_reg_r;
    logic [7:0]  cur_addr;
    logic        commit_req_r;
    logic        commit_pend_r;
    logic [12:0] frame_delay;
    adc_cfg_t    staged;
    logic        push_ready;
    logic        push;
    logic [12:0] hold_left_r;
    logic [12:0] hold_right_r;
    logic        hold_left_act_r;
    logic        hold_right_act_r;
    logic [5:0]  pay_sat;

    // Byte read decode for the read data flop; unmapped addresses give ADC_READ_UNMAPPED
    function automatic logic [7:0] reg_read(input logic [7:0] a,
                                            input logic [7:0] c, input logic [7:0] ru,
                                            input logic [7:0] rl, input logic [7:0] lu,
                                            input logic [7:0] ll, input logic [7:0] fr,
                                            input logic [7:0] pw, input logic [7:0] cm);
        case (a)
            ADC_REG_CONTROL:     reg_read = c;
            ADC_REG_RIGHT_UPPER: reg_read = ru;
            ADC_REG_RIGHT_LOWER: reg_read = rl;
            ADC_REG_LEFT_UPPER:  reg_read = lu;
            ADC_REG_LEFT_LOWER:  reg_read = ll;
            ADC_REG_FRAME_DELAY: reg_read = fr;
            ADC_REG_PAYLOAD_W:   reg_read = pw;
            ADC_REG_COMMIT:      reg_read = cm;
            default:             reg_read = ADC_READ_UNMAPPED;
        endcase
    endfunction : reg_read

    // A start loads the pointer; the byte in the same cycle uses the new address
    assign cur_addr = reg_start ? reg_addr : ptr_r;

    // Register pointer auto-increments after each byte
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ptr_r <= ADC_REG_RESET_VAL;
        end else if (reg_wr || reg_rd) begin
            ptr_r <= cur_addr + 8'h01;
        end else if (reg_start) begin
            ptr_r <= reg_addr;
        end
    end

    // Staged register file; each consecutive write lands in the next register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_r       <= ADC_REG_RESET_VAL;
            right_up_r   <= ADC_REG_RESET_VAL;
            right_lo_r   <= ADC_REG_RESET_VAL;
            left_up_r    <= ADC_REG_RESET_VAL;
            left_lo_r    <= ADC_REG_RESET_VAL;
            frame_r      <= ADC_REG_RESET_VAL;
            payload_r    <= ADC_REG_RESET_VAL;
            commit_reg_r <= ADC_REG_RESET_VAL;
        end else if (reg_wr) begin
            case (cur_addr)
                ADC_REG_CONTROL:     ctrl_r       <= reg_wdata;
                ADC_REG_RIGHT_UPPER: right_up_r   <= reg_wdata;
                ADC_REG_RIGHT_LOWER: right_lo_r   <= reg_wdata;
                ADC_REG_LEFT_UPPER:  left_up_r    <= reg_wdata;
                ADC_REG_LEFT_LOWER:  left_lo_r    <= reg_wdata;
                ADC_REG_FRAME_DELAY: frame_r      <= reg_wdata;
                ADC_REG_PAYLOAD_W:   payload_r    <= reg_wdata;
                ADC_REG_COMMIT:      commit_reg_r <= reg_wdata;
                default:             ;
            endcase
        end
    end

    // Read data from a flop, one cycle after the read strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata  <= ADC_READ_UNMAPPED;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= reg_read(cur_addr, ctrl_r, right_up_r, right_lo_r, left_up_r,
                                      left_lo_r, frame_r, payload_r, commit_reg_r);
            end
        end
    end

    // Frame delay conversion runs continuously on the staged byte
    adc_frame_calc u_frame_calc (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .frame_setting (frame_r),
        .frame_delay   (frame_delay)
    );

    // Commit request: only bit 0 counts. It waits one cycle so the frame
    // converter has seen a frame byte written just before the commit.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            commit_req_r <= 1'b0;
        end else begin
            commit_req_r <= reg_wr && (cur_addr == ADC_REG_COMMIT)
                            && reg_wdata[ADC_COMMIT_BIT];
        end
    end

    // Pending until the buffer takes the snapshot; a full buffer stalls it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            commit_pend_r <= 1'b0;
        end else if (commit_req_r) begin
            commit_pend_r <= 1'b1;
        end else if (push) begin
            commit_pend_r <= 1'b0;
        end
    end

    assign push = commit_pend_r && push_ready;

    // Payload width saturation
    assign pay_sat = (payload_r[ADC_PAYLOAD_HI:0] > ADC_PAYLOAD_MAX)
                     ? ADC_PAYLOAD_MAX : payload_r[ADC_PAYLOAD_HI:0];

    // Snapshot of staged settings; sample delay bytes are ignored in frame mode
    always_comb begin
        staged.stream_type = adc_fmt_t'(ctrl_r[1:0]);
        if (frame_r[ADC_FRAME_ENABLE]) begin
            staged.left_delay  = frame_delay;
            staged.right_delay = frame_delay;
        end else begin
            staged.left_delay  = {left_up_r[ADC_UPPER_BITS-1:0], left_lo_r};
            staged.right_delay = {right_up_r[ADC_UPPER_BITS-1:0], right_lo_r};
        end
        // Width matters only for right-justified streams; others get full width
        if (ctrl_r[1:0] == ADC_FMT_RIGHT) begin
            staged.payload_width = pay_sat;
        end else begin
            staged.payload_width = ADC_PAYLOAD_MAX;
        end
    end

    // Two-entry buffer; with the pending flag a stalled datapath keeps three commits, and further ones merge into the third
    adc_cfg_buf #(
        .W (ADC_CFG_W)
    ) u_cfg_buf (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (commit_pend_r),
        .in_ready  (push_ready),
        .in_data   (staged),
        .out_valid (cfg_valid),
        .out_ready (cfg_ready),
        .out_data  (cfg_data)
    );

    // Mute hold counters load when the buffer takes the snapshot and count samples of each channel
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hold_left_r      <= 13'h0000;
            hold_right_r     <= 13'h0000;
            hold_left_act_r  <= 1'b0;
            hold_right_act_r <= 1'b0;
        end else if (push) begin
            hold_left_r      <= staged.left_delay;
            hold_right_r     <= staged.right_delay;
            hold_left_act_r  <= (staged.left_delay != 13'h0000);
            hold_right_act_r <= (staged.right_delay != 13'h0000);
        end else if (sample_tick) begin
            if (hold_left_act_r) begin
                hold_left_r     <= hold_left_r - 13'h0001;
                hold_left_act_r <= (hold_left_r != 13'h0001);
            end
            if (hold_right_act_r) begin
                hold_right_r     <= hold_right_r - 13'h0001;
                hold_right_act_r <= (hold_right_r != 13'h0001);
            end
        end
    end

    // Control mutes act at once, without a commit
    assign mute_left   = ctrl_r[ADC_CTRL_MUTE_LEFT] || hold_left_act_r;
    assign mute_right  = ctrl_r[ADC_CTRL_MUTE_RIGHT] || hold_right_act_r;
    assign commit_busy = commit_req_r || commit_pend_r;
endmodule : adc_config
`default_nettype wire

// ==== logic/adc_frame_calc.sv ====
// Frame count to delay-in-samples converter with clamp
`timescale 1ns/1ps
`default_nettype none
module adc_frame_calc (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Frame delay setting byte
    input  wire logic [7:0]  frame_setting,
    // Resulting delay in samples
    output logic [12:0]      frame_delay
);
    import adc_pkg::*;

    logic [31:0] fs100;
    logic [31:0] frames;
    logic [31:0] samples;

    // Sample rate code lookup; codes 6 and 7 both mean 192 kHz
    function automatic logic [31:0] fs_lookup(input logic [2:0] code);
        case (code)
            3'h0:    fs_lookup = ADC_FS100_32K;
            3'h1:    fs_lookup = ADC_FS100_44K1;
            3'h2:    fs_lookup = ADC_FS100_48K;
            3'h3:    fs_lookup = ADC_FS100_88K2;
            3'h4:    fs_lookup = ADC_FS100_96K;
            3'h5:    fs_lookup = ADC_FS100_176K4;
            default: fs_lookup = ADC_FS100_192K;
        endcase
    endfunction : fs_lookup

    // Code counts frames minus one
    assign fs100  = fs_lookup(frame_setting[ADC_FRAME_FS_HI:ADC_FRAME_FS_LO]);
    assign frames = {29'h0, frame_setting[ADC_FRAME_CNT_HI:ADC_FRAME_CNT_LO]} + 32'h1;

    // Integer part of frames * fs / frame rate; division truncates
    always_comb begin
        if (frame_setting[ADC_FRAME_RATE_SEL]) begin
            samples = (frames * fs100 * ADC_RATE5994_MUL) / ADC_RATE5994_DIV;
        end else begin
            samples = frames * fs100 * ADC_RATE50_MUL;
        end
    end

    // Clamp and register; largest product stays far below 2^31
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            frame_delay <= 13'h0000;
        end else if (samples > {19'h0, ADC_DELAY_MAX}) begin
            frame_delay <= ADC_DELAY_MAX;
        end else begin
            frame_delay <= samples[12:0];
        end
    end
endmodule : adc_frame_calc
`default_nettype wire

// ==== logic/adc_pkg.sv ====
// Package for the audio delay frame configuration and commit register bank
package adc_pkg;
    // Register indices on the byte port
    localparam logic [7:0] ADC_REG_CONTROL     = 8'h01;
    localparam logic [7:0] ADC_REG_RIGHT_UPPER = 8'h02;
    localparam logic [7:0] ADC_REG_RIGHT_LOWER = 8'h03;
    localparam logic [7:0] ADC_REG_LEFT_UPPER  = 8'h04;
    localparam logic [7:0] ADC_REG_LEFT_LOWER  = 8'h05;
    localparam logic [7:0] ADC_REG_FRAME_DELAY = 8'h06;
    localparam logic [7:0] ADC_REG_PAYLOAD_W   = 8'h07;
    localparam logic [7:0] ADC_REG_COMMIT      = 8'h08;
    localparam logic [7:0] ADC_REG_RESET_VAL   = 8'h00;
    localparam logic [7:0] ADC_READ_UNMAPPED   = 8'h00;

    // Field positions
    localparam int ADC_CTRL_MUTE_RIGHT = 7;
    localparam int ADC_CTRL_MUTE_LEFT  = 6;
    localparam int ADC_FRAME_ENABLE    = 7;
    localparam int ADC_FRAME_RATE_SEL  = 6;
    localparam int ADC_FRAME_FS_HI     = 5;
    localparam int ADC_FRAME_FS_LO     = 3;
    localparam int ADC_FRAME_CNT_HI    = 2;
    localparam int ADC_FRAME_CNT_LO    = 0;
    localparam int ADC_PAYLOAD_HI      = 5;
    localparam int ADC_COMMIT_BIT      = 0;
    localparam int ADC_UPPER_BITS      = 5;

    // Widths and limits
    localparam int          ADC_DELAY_W      = 13;
    localparam logic [12:0] ADC_DELAY_MAX    = 13'h1FFF;  // 8191 samples
    localparam logic [5:0]  ADC_PAYLOAD_MAX  = 6'h18;     // 24 bits

    // Frame arithmetic: sample rates in units of 100 Hz
    localparam logic [31:0] ADC_FS100_32K   = 32'h0000_0140;  // 320
    localparam logic [31:0] ADC_FS100_44K1  = 32'h0000_01B9;  // 441
    localparam logic [31:0] ADC_FS100_48K   = 32'h0000_01E0;  // 480
    localparam logic [31:0] ADC_FS100_88K2  = 32'h0000_0372;  // 882
    localparam logic [31:0] ADC_FS100_96K   = 32'h0000_03C0;  // 960
    localparam logic [31:0] ADC_FS100_176K4 = 32'h0000_06E4;  // 1764
    localparam logic [31:0] ADC_FS100_192K  = 32'h0000_0780;  // 1920
    // 50 Hz: fs/50 = fs100*2
    localparam logic [31:0] ADC_RATE50_MUL  = 32'h0000_0002;
    // 59.94 Hz: fs/59.94 = fs100*5000/2997
    localparam logic [31:0] ADC_RATE5994_MUL = 32'h0000_1388;  // 5000
    localparam logic [31:0] ADC_RATE5994_DIV = 32'h0000_0BB5;  // 2997

    // Stream formats
    typedef enum logic [1:0] {
        ADC_FMT_I2S    = 2'h0,
        ADC_FMT_RIGHT  = 2'h1,
        ADC_FMT_LEFT   = 2'h2,
        ADC_FMT_BYPASS = 2'h3
    } adc_fmt_t;

    // Settings handed to the delay datapath on a commit
    typedef struct packed {
        adc_fmt_t    stream_type;
        logic [12:0] left_delay;
        logic [12:0] right_delay;
        logic [5:0]  payload_width;
    } adc_cfg_t;

    localparam int ADC_CFG_W = $bits(adc_cfg_t);
endpackage : adc_pkg

// ==== testbench/adc_config_props.sv ====
// Concurrent checks on the configuration bank ports
`timescale 1ns/1ps
`default_nettype none
module adc_config_props (
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              rst,
    // Register byte port
    input wire logic              reg_start,
    input wire logic [7:0]        reg_addr,
    input wire logic              reg_wr,
    input wire logic [7:0]        reg_wdata,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_rdata,
    input wire logic              reg_rvalid,
    // Datapath side
    input wire logic              cfg_valid,
    input wire logic              cfg_ready,
    input wire adc_pkg::adc_cfg_t cfg_data,
    input wire logic              sample_tick,
    input wire logic              mute_left,
    input wire logic              mute_right,
    input wire logic              commit_busy
);
    import adc_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Only writes that name their register are judged; pointer runs are not tracked here
    wire logic wr_ctrl   = reg_start && reg_wr && reg_addr == ADC_REG_CONTROL;
    wire logic wr_commit = reg_start && reg_wr && reg_addr == ADC_REG_COMMIT;

    AST_READ_ANSWER: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered one cycle later");
    AST_NO_STRAY_READ: assert property (!reg_rd |=> !reg_rvalid)
        else $error("read answer without a read");
    AST_UNMAPPED_ZERO: assert property (reg_start && reg_rd
        && (reg_addr == 8'h00 || reg_addr > ADC_REG_COMMIT)
        |=> reg_rdata == ADC_READ_UNMAPPED) else $error("unmapped read not zero");
    AST_COMMIT_TAKEN: assert property (wr_commit && reg_wdata[ADC_COMMIT_BIT] |=> commit_busy)
        else $error("commit write not taken");
    AST_COMMIT_ZERO: assert property (wr_commit && !reg_wdata[ADC_COMMIT_BIT]
        && !commit_busy && !$past(reg_wr) |=> !commit_busy) else $error("zero commit started a transfer");
    AST_PUSH_PROMPT: assert property ($rose(commit_busy) && !cfg_valid
        |-> ##[1:2] (cfg_valid && !commit_busy)) else $error("commit not pushed into empty buffer");
    AST_MUTE_LEFT_NOW: assert property (wr_ctrl && reg_wdata[ADC_CTRL_MUTE_LEFT] |=> mute_left)
        else $error("left mute late");
    AST_MUTE_RIGHT_NOW: assert property (wr_ctrl && reg_wdata[ADC_CTRL_MUTE_RIGHT] |=> mute_right)
        else $error("right mute late");
    AST_CFG_HOLD: assert property (cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_data))
        else $error("settings dropped while stalled");
    AST_WIDTH_CAP: assert property (cfg_valid |-> cfg_data.payload_width <= ADC_PAYLOAD_MAX)
        else $error("payload width above cap");

    // Main scenarios reached
    COV_COMMIT: cover property (wr_commit && reg_wdata[ADC_COMMIT_BIT]);
    COV_STALL: cover property (cfg_valid && !cfg_ready && commit_busy);
    COV_HOLD_END: cover property ($fell(mute_left));
endmodule : adc_config_props

bind adc_config adc_config_props adc_config_props_inst (.clk_sys(clk_sys), .rst(rst), .reg_start(reg_start),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_data(cfg_data),
    .sample_tick(sample_tick), .mute_left(mute_left), .mute_right(mute_right), .commit_busy(commit_busy));
`default_nettype wire

// ==== testbench/adc_host_model.sv ====
// Bus master model driving the register byte port
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
    // Clock
    input wire logic        clk_sys,
    // Register byte port
    output logic            reg_start,
    output logic [7:0]      reg_addr,
    output logic            reg_wr,
    output logic [7:0]      reg_wdata,
    output logic            reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_rvalid
);
    import adc_pkg::*;
    // Idle lines at time zero
    initial begin
        reg_start = 1'b0;
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
    end
    // Released lines flip so a stale value is never mistaken for a fresh one
    task automatic idle;
        reg_start = 1'b0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = ~reg_addr;
        reg_wdata = ~reg_wdata;
        @(posedge clk_sys);
        #1;
    endtask : idle
    // One write byte; the pointer is loaded only on the first byte of a run
    task automatic put(input logic first, input logic [7:0] a, input logic [7:0] d);
        reg_start = first;
        reg_addr  = a;
        reg_wr    = 1'b1;
        reg_wdata = d;
        @(posedge clk_sys);
        #1;
    endtask : put
    // One read byte, taken while the answer stands
    task automatic get(input logic first, input logic [7:0] a, output logic [7:0] q);
        reg_start = first;
        reg_addr  = a;
        reg_rd    = 1'b1;
        @(posedge clk_sys);
        #1;
        q = reg_rvalid ? reg_rdata : 8'hXX;
    endtask : get
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        put(1'b1, a, d);
        idle();
    endtask : wr_byte
    // Whole bank from the control register on, so no register is left unwritten
    task automatic wr_all(input logic [63:0] d);
        for (int i = 0; i < 8; i++) put(i == 0, ADC_REG_CONTROL, d[63 - 8 * i -: 8]);
        idle();
    endtask : wr_all
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] q);
        get(1'b1, a, q);
        idle(); // Last byte ends the run, as a not-acknowledge then stop would
    endtask : rd_byte
    task automatic rd_all(output logic [63:0] q);
        for (int i = 0; i < 8; i++) get(i == 0, ADC_REG_CONTROL, q[63 - 8 * i -: 8]);
        idle();
    endtask : rd_all
endmodule : adc_host_model
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import adc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic sample_tick = 1'b0;
    logic cfg_ready = 1'b0;
    logic reg_start, reg_wr, reg_rd, reg_rvalid, cfg_valid, mute_left, mute_right, commit_busy;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    adc_cfg_t cfg_data;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;

    adc_host_model adc_host_model_inst (.clk_sys(clk_sys), .reg_start(reg_start), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    adc_config adc_config_inst (.clk_sys(clk_sys), .rst(rst), .reg_start(reg_start), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_data(cfg_data), .sample_tick(sample_tick),
        .mute_left(mute_left), .mute_right(mute_right), .commit_busy(commit_busy));

    // 20 MHz clock and hang guard
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic report_and_stop;
        if (err_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    // Audio sample pulses, one idle cycle between them
    task automatic ticks(input int n);
        repeat (n) begin
            sample_tick = 1'b1; // One pulse per whole word, never shorter than the payload
            step(1);
            sample_tick = 1'b0;
            step(1);
        end
    endtask : ticks
    // Pop one committed set of settings; waiting is bounded
    task automatic take_cfg(output adc_cfg_t c);
        int k;
        k = 0;
        while (cfg_valid !== 1'b1 && k < 8) begin
            step(1);
            k++;
        end
        check("cfg_valid", cfg_valid, 1'b1);
        c = cfg_data;
        cfg_ready = 1'b1;
        step(1);
        cfg_ready = 1'b0;
        step(1);
    endtask : take_cfg

    task automatic t_reset;
        logic [63:0] q;
        logic [7:0] b;
        adc_host_model_inst.rd_all(q);
        check("reset values", q, 64'h0);
        adc_host_model_inst.wr_byte(8'h09, 8'hAA);
        adc_host_model_inst.rd_byte(8'h09, b);
        check("unmapped 09", b, ADC_READ_UNMAPPED);
        adc_host_model_inst.rd_byte(8'h00, b);
        check("unmapped 00", b, ADC_READ_UNMAPPED);
    endtask : t_reset
    // Mute bits act with no commit at all
    task automatic t_mute;
        adc_host_model_inst.wr_byte(ADC_REG_CONTROL, 8'hC0);
        check("both muted", {mute_left, mute_right}, 2'h3);
        adc_host_model_inst.wr_byte(ADC_REG_CONTROL, 8'h40);
        check("left muted", {mute_left, mute_right}, 2'h2);
        adc_host_model_inst.wr_byte(ADC_REG_CONTROL, 8'h80);
        check("right muted", {mute_left, mute_right}, 2'h1);
    endtask : t_mute
    // Full sequential write with commit bit clear, read back in one run
    task automatic t_roundtrip;
        logic [63:0] q;
        adc_host_model_inst.wr_all(64'h02_1F_FF_0A_55_7F_3F_FE);
        adc_host_model_inst.rd_all(q);
        check("readback", q, 64'h02_1F_FF_0A_55_7F_3F_FE);
        adc_host_model_inst.wr_byte(ADC_REG_COMMIT, 8'hFE);
        check("no transfer on zero", {cfg_valid, commit_busy}, 2'h0);
    endtask : t_roundtrip
    // Sample delays 30 and 300 committed; mutes hold for exactly that many samples
    task automatic t_delay;
        adc_cfg_t c;
        adc_host_model_inst.wr_all(64'h01_00_1E_01_2C_00_3F_01); // Commit follows the delay change
        take_cfg(c);
        check("sample delay cfg", c, {ADC_FMT_RIGHT, 13'h012C, 13'h001E, 6'h18});
        ticks(29);
        check("right held", {mute_left, mute_right}, 2'h3);
        ticks(1);
        check("right freed", {mute_left, mute_right}, 2'h2);
        ticks(269);
        check("left held", mute_left, 1'b1);
        ticks(1);
        check("left freed", mute_left, 1'b0);
        adc_host_model_inst.wr_byte(ADC_REG_PAYLOAD_W, 8'h10);
        adc_host_model_inst.wr_byte(ADC_REG_COMMIT, 8'h01);
        take_cfg(c);
        check("width 16", c.payload_width, 6'h10);
    endtask : t_delay
    // Every sample code, both frame rates, counts 8 down to 1, sample delays at full scale
    task automatic t_frame;
        adc_cfg_t c;
        logic [31:0] fs100 [8];
        longint e;
        fs100 = '{ADC_FS100_32K, ADC_FS100_44K1, ADC_FS100_48K, ADC_FS100_88K2, ADC_FS100_96K,
                  ADC_FS100_176K4, ADC_FS100_192K, ADC_FS100_192K};
        adc_host_model_inst.wr_all(64'h00_1F_FF_1F_FF_00_10_00);
        for (int s = 0; s < 8; s++) begin
            e = (8 - s) * fs100[s];
            e = s[0] ? e * ADC_RATE5994_MUL / ADC_RATE5994_DIV : e * ADC_RATE50_MUL;
            if (e > ADC_DELAY_MAX) e = ADC_DELAY_MAX;
            adc_host_model_inst.wr_byte(ADC_REG_FRAME_DELAY, {1'b1, s[0], s[2:0], 3'h7 - s[2:0]});
            adc_host_model_inst.wr_byte(ADC_REG_COMMIT, 8'hFF); // High bits are don't-care
            take_cfg(c);
            check("frame cfg", c, {ADC_FMT_I2S, e[12:0], e[12:0], 6'h18});
        end
    endtask : t_frame
    // Three commits against a stalled datapath: two buffered, third waits
    task automatic t_buffer;
        adc_cfg_t c;
        adc_host_model_inst.wr_byte(ADC_REG_CONTROL, 8'h01);
        for (int i = 5; i < 8; i++) begin
            adc_host_model_inst.wr_byte(ADC_REG_PAYLOAD_W, i[7:0]);
            adc_host_model_inst.wr_byte(ADC_REG_COMMIT, 8'h01);
            step(3);
        end
        check("busy while full", {cfg_valid, commit_busy}, 2'h3);
        for (int i = 5; i < 8; i++) begin
            take_cfg(c);
            check("queued width", c.payload_width, i[5:0]);
        end
        check("drained", cfg_valid, 1'b0);
    endtask : t_buffer

    // Reset, then the scenarios in order
    initial begin
        step(8);
        rst = 1'b0;
        t_reset();
        t_mute();
        t_roundtrip();
        t_delay();
        t_frame();
        t_buffer();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
